// file: achp_card_model.sv
// behavioural card: register store, read drive, slow ready
`timescale 1ns/10ps
module achp_card_model (
  input wire logic clk,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [2:0] addr,
  input wire logic [15:0] dout,
  input wire logic slow, // stretch every strobe
  output logic [15:0] bus,
  output logic ready
);
  logic [15:0] mem [8];
  logic [5:0] wait_cnt;
  // host wins while driving, card only under read strobe, else pull-down
  assign bus = !oe_n ? dout : (!rd_n ? mem[addr] : 16'h0000);
  assign ready = (wait_cnt == 6'h00);
  // word taken at the end of the write strobe
  always @(posedge wr_n)
    mem[addr] <= bus;
  // with slow set, ready held low for 40 clocks after each strobe starts
  always @(posedge clk)
    wait_cnt <= (rd_n && wr_n) ? (slow ? 6'h28 : 6'h00) : (wait_cnt != 6'h00 ? wait_cnt - 6'h01 : 6'h00);
endmodule

// file: achp_fifo.sv
// small valid/ready fifo holding words read from the card
`timescale 1ns/10ps
module achp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count; // occupancy, one bit wider for full
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule

// file: achp_host_port.sv
// ide-compatible card host port: bus cycle sequencer, pins, read fifo
`timescale 1ns/10ps
module achp_host_port (
  input wire logic ref_clk,
  input wire logic arst_n,
  // user request side
  input wire logic req_valid, // start a bus cycle
  output logic req_ready, // sequencer idle, room for read data, card present and out of hardware reset
  input wire logic req_write, // 1 write, 0 read
  input wire logic req_alt, // target the alternate register group
  input wire logic req_data, // 16-bit data transfer, else task-file byte
  input wire logic [2:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data,
  input wire logic card_reset_req, // hold card in hardware reset
  output logic card_present,
  output logic card_irq_pending,
  output logic card_is_ready,
  // card pins
  output logic card_select_primary_n,
  output logic card_select_alternate_n,
  output logic reg_addr_bit2,
  output logic reg_addr_bit1,
  output logic reg_addr_bit0,
  output logic card_read_strobe_n,
  output logic card_write_strobe_n,
  output logic card_hw_reset_n,
  input wire logic [7:0] card_data_hi_in,
  input wire logic [7:0] card_data_lo_in,
  output logic [7:0] card_data_hi_out,
  output logic [7:0] card_data_lo_out,
  output logic card_data_oe_n, // low while this end drives the bus
  input wire logic card_irq,
  input wire logic card_ready_in,
  input wire logic card_detect_a_n,
  input wire logic card_detect_b_n
);
  ////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin input synchronisers; first stage read only by second
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [15:0] din_s1;
  logic [15:0] din_s2; // read data, both bytes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 4'hF;
      sync2 <= 4'hF;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end else begin
      sync1 <= {card_irq, card_ready_in, card_detect_a_n, card_detect_b_n};
      sync2 <= sync1;
      din_s1 <= {card_data_hi_in, card_data_lo_in};
      din_s2 <= din_s1;
    end
  end
  // irq reset value of the chain reads as pending only after the card drives it
  assign card_irq_pending = sync2[3] && card_present;
  assign card_is_ready = sync2[2];
  assign card_present = !sync2[1] && !sync2[0];

  ////////////////////////////////////////////////////////////////
  // read data fifo
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_in_data;
  achp_fifo #(.WIDTH(achp_pkg::DATA_W), .DEPTH(achp_pkg::FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////
  // sequencer state
  achp_pkg::achp_state_t state;
  achp_pkg::achp_state_t next_state;
  logic [achp_pkg::CNT_W-1:0] cnt;
  logic cyc_write; // latched request
  logic cyc_alt;
  logic cyc_data;
  logic [2:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic cyc_active; // selects asserted
  logic push_pulse;

  // a read is taken only with room in the fifo: back-pressure stalls the bus
  wire idle = (state == achp_pkg::ACHP_IDLE);
  assign req_ready = idle && fifo_in_ready && card_present && card_hw_reset_n;
  wire take = req_valid && req_ready;
  wire cnt_done = (cnt == '0);
  wire ready_hi = sync2[2];

  // next-state decode
  always_comb begin
    next_state = state;
    unique case (state)
      achp_pkg::ACHP_IDLE: if (take) next_state = achp_pkg::ACHP_SETUP;
      achp_pkg::ACHP_SETUP: if (cnt_done) next_state = achp_pkg::ACHP_STROBE;
      // strobe stretched while ready low
      achp_pkg::ACHP_STROBE: if (cnt_done && ready_hi) next_state = achp_pkg::ACHP_HOLD;
      achp_pkg::ACHP_HOLD: if (cnt_done) next_state = achp_pkg::ACHP_IDLE;
      default: next_state = achp_pkg::ACHP_IDLE;
    endcase
  end

  // state and phase counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= achp_pkg::ACHP_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      if (take) cnt <= achp_pkg::CNT_W'(achp_pkg::SETUP_CYC - 1);
      else if (state == achp_pkg::ACHP_SETUP && cnt_done) cnt <= achp_pkg::CNT_W'(achp_pkg::STROBE_CYC - 1);
      else if (state == achp_pkg::ACHP_STROBE && cnt_done && ready_hi) cnt <= achp_pkg::CNT_W'(achp_pkg::HOLD_CYC - 1);
      else if (!cnt_done) cnt <= cnt - 1'b1;
    end
  end

  // request latch; address held stable for the whole cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_write <= 1'b0;
      cyc_alt <= 1'b0;
      cyc_data <= 1'b0;
      cyc_addr <= 3'h0;
      cyc_wdata <= 16'h0000;
    end else if (take) begin
      cyc_write <= req_write;
      cyc_alt <= req_alt;
      cyc_data <= req_data;
      cyc_addr <= req_addr;
      // register writes carry only the low byte
      cyc_wdata <= req_data ? req_wdata : {8'h00, req_wdata[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drivers, all registered
  wire strobe_next = (next_state == achp_pkg::ACHP_STROBE);
  wire active_next = (next_state != achp_pkg::ACHP_IDLE);
  wire sample = (state == achp_pkg::ACHP_STROBE) && (next_state == achp_pkg::ACHP_HOLD) && !cyc_write;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_active <= 1'b0;
      card_select_primary_n <= 1'b1;
      card_select_alternate_n <= 1'b1;
      card_read_strobe_n <= 1'b1;
      card_write_strobe_n <= 1'b1;
      card_data_oe_n <= 1'b1;
      card_hw_reset_n <= 1'b0;
      push_pulse <= 1'b0;
      fifo_in_data <= 16'h0000;
    end else begin
      cyc_active <= active_next;
      card_select_primary_n <= !(active_next && !(take ? req_alt : cyc_alt));
      card_select_alternate_n <= !(active_next && (take ? req_alt : cyc_alt));
      card_read_strobe_n <= !(strobe_next && !cyc_write);
      card_write_strobe_n <= !(strobe_next && cyc_write);
      // bus driven only during a write cycle
      card_data_oe_n <= !(active_next && (take ? req_write : cyc_write));
      card_hw_reset_n <= !card_reset_req;
      push_pulse <= sample;
      // read sampled as strobe ends; task-file read keeps low byte
      if (sample) fifo_in_data <= cyc_data ? din_s2 : {8'h00, din_s2[7:0]};
    end
  end
  assign fifo_in_valid = push_pulse;

  // address and write data outputs
  assign reg_addr_bit2 = cyc_addr[2];
  assign reg_addr_bit1 = cyc_addr[1];
  assign reg_addr_bit0 = cyc_addr[0];
  assign card_data_hi_out = cyc_wdata[15:8];
  assign card_data_lo_out = cyc_wdata[7:0];
endmodule

// file: achp_host_port_chk.sv
// assertions on the card host port pins and status outputs
`timescale 1ns/10ps
module achp_host_port_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic card_reset_req,
  input wire logic card_hw_reset_n,
  input wire logic card_select_primary_n,
  input wire logic card_select_alternate_n,
  input wire logic card_read_strobe_n,
  input wire logic card_write_strobe_n,
  input wire logic card_data_oe_n,
  input wire logic [7:0] card_data_lo_out,
  input wire logic card_detect_a_n,
  input wire logic card_detect_b_n,
  input wire logic card_present,
  input wire logic card_irq,
  input wire logic card_irq_pending,
  input wire logic card_ready_in,
  input wire logic card_is_ready
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  rd_select_a: assert property (!card_read_strobe_n |-> !(card_select_primary_n && card_select_alternate_n))
    else $error("read strobe without select");
  sel_excl_a: assert property (!(!card_select_primary_n && !card_select_alternate_n))
    else $error("both selects low");
  rd_release_a: assert property (!card_read_strobe_n |-> card_data_oe_n)
    else $error("bus driven during read");
  wr_drive_a: assert property (!card_write_strobe_n |-> !card_data_oe_n)
    else $error("write strobe without data");
  wr_stable_a: assert property (!card_write_strobe_n && !$past(card_write_strobe_n) |-> $stable(card_data_lo_out))
    else $error("write data moved");
  setup_sel_a: assert property ($fell(card_write_strobe_n) |-> !$past(card_select_primary_n, 8)
    || !$past(card_select_alternate_n, 8))
    else $error("select setup short");
  stretch_a: assert property ($rose(card_read_strobe_n) |-> $past(card_is_ready))
    else $error("strobe ended while not ready");
  reset_pin_a: assert property (card_reset_req |=> !card_hw_reset_n)
    else $error("card reset not driven");
  present_a: assert property ((!card_detect_a_n && !card_detect_b_n) [*6] |-> card_present)
    else $error("card not seen");
  absent_a: assert property (card_detect_a_n [*6] |-> !card_present)
    else $error("missing card seen");
  irq_seen_a: assert property (card_irq [*6] ##0 card_present |-> card_irq_pending)
    else $error("irq not pending");
  ready_seen_a: assert property (card_ready_in [*6] |-> card_is_ready)
    else $error("ready not seen");
  rd_cov: cover property ($rose(card_read_strobe_n));
  wr_cov: cover property ($rose(card_write_strobe_n));
  irq_cov: cover property ($rose(card_irq_pending));
endmodule
bind achp_host_port achp_host_port_chk i_chk (.*);

// file: achp_host_port_tb_top.sv
// testbench for the card host port with card model
`timescale 1ns/10ps
module achp_host_port_tb_top;
  logic ref_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_alt = 1'b0, req_data = 1'b0;
  logic [2:0] req_addr = 3'h0;
  logic [15:0] req_wdata = 16'h0000, rd_data, bus;
  logic rd_ready = 1'b0, card_reset_req = 1'b0, card_irq = 1'b0, card_detect_a_n = 1'b0, card_detect_b_n = 1'b0;
  logic slow = 1'b0, req_ready, rd_valid, card_present, card_irq_pending, card_is_ready, card_ready_in;
  logic card_select_primary_n, card_select_alternate_n, reg_addr_bit2, reg_addr_bit1, reg_addr_bit0;
  logic card_read_strobe_n, card_write_strobe_n, card_hw_reset_n, card_data_oe_n;
  logic [7:0] card_data_hi_in, card_data_lo_in, card_data_hi_out, card_data_lo_out;
  int fails = 0, check_count = 0;
  always #4 ref_clk = ~ref_clk;
  assign {card_data_hi_in, card_data_lo_in} = bus;
  achp_host_port i_dut (.*);
  achp_card_model i_card (.clk(ref_clk), .rd_n(card_read_strobe_n), .wr_n(card_write_strobe_n),
    .oe_n(card_data_oe_n), .addr({reg_addr_bit2, reg_addr_bit1, reg_addr_bit0}),
    .dout({card_data_hi_out, card_data_lo_out}), .slow(slow), .bus(bus), .ready(card_ready_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] val(input int i);
    return 16'(16'hA5C3 + i * 16'h1111);
  endfunction
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // waits for the port to go idle, then holds the request for one edge
  task automatic req(input logic w, input logic alt, input logic dat, input logic [2:0] a, input logic [15:0] wd);
    for (int n = 0; n < 400 && req_ready !== 1'b1; n++)
      @(negedge ref_clk);
    // a port that never goes idle is a mismatch, not a silent skip
    if (req_ready !== 1'b1) fails++;
    {req_write, req_alt, req_data, req_addr, req_wdata} = {w, alt, dat, a, wd};
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  // ready raised only once data stands; one idle edge keeps back-to-back pops apart
  task automatic pop(input logic [15:0] exp);
    for (int n = 0; n < 400 && rd_valid !== 1'b1; n++)
      @(negedge ref_clk);
    if (rd_valid !== 1'b1) fails++;
    cmp("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    @(negedge ref_clk);
    rd_ready = 1'b0;
    @(negedge ref_clk);
  endtask
  // full words to every address, fifo filled until refused, one slow read
  task automatic t_words;
    for (int i = 0; i < 8; i++)
      req(1'b1, 1'b0, 1'b1, 3'(i), val(i));
    for (int i = 0; i < 4; i++)
      req(1'b0, 1'b0, 1'b1, 3'(i), 16'h0000);
    repeat (60) @(negedge ref_clk);
    cmp1("req_ready", 1'b0, req_ready);
    for (int i = 0; i < 4; i++)
      pop(val(i));
    slow = 1'b1;
    req(1'b0, 1'b0, 1'b1, 3'h7, 16'h0000);
    pop(val(7));
    slow = 1'b0;
  endtask
  // task-file bytes on both selects carry the low byte only
  task automatic t_bytes;
    logic [15:0] v;
    v = val(2);
    req(1'b1, 1'b1, 1'b0, 3'h5, 16'hA5C3);
    req(1'b0, 1'b1, 1'b0, 3'h5, 16'h0000);
    pop(16'h00C3);
    req(1'b0, 1'b0, 1'b0, 3'h2, 16'h0000);
    pop({8'h00, v[7:0]});
  endtask
  task automatic t_pins;
    card_irq = 1'b1;
    repeat (6) @(negedge ref_clk);
    cmp1("card_irq_pending", 1'b1, card_irq_pending);
    card_detect_b_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    cmp1("card_present", 1'b0, card_present);
    {card_detect_a_n, card_detect_b_n} = 2'h2;
    repeat (6) @(negedge ref_clk);
    cmp1("card_present", 1'b0, card_present);
    {card_detect_a_n, card_irq, card_reset_req} = 3'h1;
    repeat (6) @(negedge ref_clk);
    cmp1("card_hw_reset_n", 1'b0, card_hw_reset_n);
    cmp1("req_ready", 1'b0, req_ready);
    card_reset_req = 1'b0;
    repeat (6) @(negedge ref_clk);
    cmp1("card_hw_reset_n", 1'b1, card_hw_reset_n);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    t_words();
    t_bytes();
    t_pins();
    results();
  end
  initial begin
    #200000;
    fails++;
    results();
  end
endmodule

// file: achp_pkg.sv
// constants shared by the card host port and its fifo
package achp_pkg;
  // widths and fifo depth
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned FIFO_DEPTH = 4;
  // clock period and bus timing, in ns
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SETUP_NS = 70;
  localparam int unsigned STROBE_NS = 165;
  localparam int unsigned HOLD_NS = 30;
  // least times round up to whole cycles
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 5;
  // bus cycle sequencer, gray codes along the path
  typedef enum logic [2:0] {
    ACHP_IDLE = 3'h0,
    ACHP_SETUP = 3'h1,
    ACHP_STROBE = 3'h3,
    ACHP_HOLD = 3'h2
  } achp_state_t;
endpackage
